// [inc/cat_pkg.sv]
// Package for the capture and interval timer block.
// Assumes one 250 MHz clock and an 8-bit register port.
package cat_pkg;

  localparam int CLK_MHZ = 250;

  // Register offsets (byte addresses on the register port)
  localparam logic [7:0] OFF_CAP0_RISE   = 8'h22;
  localparam logic [7:0] OFF_CAP1_RISE   = 8'h23;
  localparam logic [7:0] OFF_CAP0_FALL   = 8'h24;
  localparam logic [7:0] OFF_CAP1_FALL   = 8'h25;
  localparam logic [7:0] OFF_CNT_LOW     = 8'h26;
  localparam logic [7:0] OFF_CNT_UPPER   = 8'h27;
  localparam logic [7:0] OFF_RELOAD_LOW  = 8'h28;
  localparam logic [7:0] OFF_RELOAD_UP   = 8'h29;
  localparam logic [7:0] OFF_CFG         = 8'h2A;
  localparam logic [7:0] OFF_IRQ_ENABLE  = 8'h2B;
  localparam logic [7:0] OFF_IRQ_FLAGS   = 8'h2C;

  // Field positions and masks of the configuration register
  localparam int         CFG_HOLD_BIT    = 7;
  localparam int         CFG_PRE_LSB     = 4;
  localparam int         CFG_CHAIN_BIT   = 3;
  localparam logic [7:0] CFG_MASK        = 8'hF8;
  localparam logic [7:0] NIBBLE_MASK     = 8'h0F;

  // Edge index inside the enable and flag registers
  localparam int         EDGE_C0_RISE    = 0;
  localparam int         EDGE_C0_FALL    = 1;
  localparam int         EDGE_C1_RISE    = 2;
  localparam int         EDGE_C1_FALL    = 3;

  // Reset values
  localparam logic [7:0] RST_BYTE        = 8'h00;
  localparam logic [3:0] RST_NIBBLE      = 4'h0;
  localparam logic [15:0] RST_FRT        = 16'h0000;
  localparam logic [11:0] RST_COUNT      = 12'h000;

  typedef struct packed {
    logic [2:0] pipe;
  } cat_sync_t;

  typedef struct packed {
    logic [11:0] count;
    logic        expire;
  } cat_ivl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } cat_bus_t;

  typedef struct packed {
    logic [15:0]     frt;
    logic [3:0]      cnt_hold;
    logic [7:0]      rl_low;
    logic [3:0]      rl_up;
    logic [7:0]      cfg;
    logic [3:0]      ien;
    logic [3:0]      flags;
    logic [3:0][7:0] cap;
    logic [3:0]      full;
    logic [7:0]      rdata;
    logic            irq;
    logic            pit;
  } cat_top_t;

endpackage

// [src/cat_interval.sv]
// 12-bit down-counting interval timer with reload.
// Assumes the reload value is stable or changes only by register writes.
`timescale 1ns/1ps
module cat_interval #(
  parameter int WIDTH = 12
) (
  input  wire logic             clk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] reload_in,
  output logic [WIDTH-1:0]      count_out,
  output logic                  expire_out
);
  cat_pkg::cat_ivl_t state_reg;
  cat_pkg::cat_ivl_t state_next;

  always_comb begin
    state_next        = state_reg;
    state_next.expire = 1'b0;
    if (state_reg.count == '0) begin
      state_next.count  = reload_in;
      state_next.expire = 1'b1;
    end else begin
      state_next.count = state_reg.count - 12'h001;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= '{count: cat_pkg::RST_COUNT, expire: 1'b0};
    end else begin
      state_reg <= state_next;
    end
  end

  assign count_out  = state_reg.count;
  assign expire_out = state_reg.expire;
endmodule

// [src/cat_pin_sync.sv]
// Three-stage synchroniser with edge detection for one capture pin.
// Assumes the pin is asynchronous to clk_in.
`timescale 1ns/1ps
module cat_pin_sync (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic pin_in,
  output logic      rise_out,
  output logic      fall_out
);
  cat_pkg::cat_sync_t state_reg;
  cat_pkg::cat_sync_t state_next;

  always_comb begin
    state_next      = state_reg;
    state_next.pipe = {state_reg.pipe[1:0], pin_in};
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Stage 0 feeds only stage 1; edges come from stages 1 and 2
  assign rise_out = state_reg.pipe[1] & ~state_reg.pipe[2];
  assign fall_out = ~state_reg.pipe[1] & state_reg.pipe[2];
endmodule

// [src/cat_timer_top.sv]
// Capture timer and programmable interval timer register block.
// Assumes a single clock, an 8-bit register port and two async capture pins.
`timescale 1ns/1ps

module cat_timer_top (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic       capture_input_zero_in,
  input  wire logic       capture_input_one_in,
  output logic [7:0]      rdata_out,
  output logic            irq_out,
  output logic            interval_event_out
);

  cat_pkg::cat_top_t state_reg;
  cat_pkg::cat_top_t state_next;
  cat_pkg::cat_bus_t bus;

  logic [1:0]  rise;
  logic [1:0]  fall;
  logic [3:0]  edge_ev;
  logic [11:0] ivl_count;
  logic        ivl_expire;
  logic [11:0] reload;

  function automatic logic hit(input cat_pkg::cat_bus_t b, input logic [7:0] off);
    hit = (b.addr == off);
  endfunction

  // Capture register index for an address, or 3'h4 when none
  function automatic logic [2:0] cap_index(input logic [7:0] a);
    case (a)
      cat_pkg::OFF_CAP0_RISE: cap_index = 3'(cat_pkg::EDGE_C0_RISE);
      cat_pkg::OFF_CAP0_FALL: cap_index = 3'(cat_pkg::EDGE_C0_FALL);
      cat_pkg::OFF_CAP1_RISE: cap_index = 3'(cat_pkg::EDGE_C1_RISE);
      cat_pkg::OFF_CAP1_FALL: cap_index = 3'(cat_pkg::EDGE_C1_FALL);
      default:                cap_index = 3'h4;
    endcase
  endfunction

  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pin
      cat_pin_sync u_sync (
        .clk_in    (clk_in),
        .resetn_in (resetn_in),
        .pin_in    (g == 0 ? capture_input_zero_in : capture_input_one_in),
        .rise_out  (rise[g]),
        .fall_out  (fall[g])
      );
    end
  endgenerate

  assign edge_ev = {fall[1], rise[1], fall[0], rise[0]};
  assign reload  = {state_reg.rl_up, state_reg.rl_low};

  cat_interval #(
    .WIDTH (12)
  ) u_interval (
    .clk_in     (clk_in),
    .resetn_in  (resetn_in),
    .reload_in  (reload),
    .count_out  (ivl_count),
    .expire_out (ivl_expire)
  );

  always_comb begin
    logic        hold;
    logic        chain;
    logic [2:0]  pre;
    logic [7:0]  sel;
    logic [3:0]  live;
    logic [2:0]  ci;
    hold  = state_reg.cfg[cat_pkg::CFG_HOLD_BIT];
    chain = state_reg.cfg[cat_pkg::CFG_CHAIN_BIT];
    pre   = state_reg.cfg[cat_pkg::CFG_PRE_LSB +: 3];
    sel   = 8'(state_reg.frt >> pre);
    // Input one is dead while chained
    live  = chain ? 4'h3 : 4'hF;
    ci    = cap_index(bus.addr);

    state_next       = state_reg;
    state_next.frt   = state_reg.frt + 16'h0001;
    state_next.rdata = cat_pkg::RST_BYTE;
    state_next.pit   = ivl_expire;

    // Reads: data appear one cycle later; reserved bits return zero
    if (bus.rd) begin
      if (ci != 3'h4) begin
        state_next.rdata = state_reg.cap[ci[1:0]];
        // A read rearms first-edge hold for that register
        state_next.full[ci[1:0]] = 1'b0;
      end else begin
        case (bus.addr)
          cat_pkg::OFF_CNT_LOW: begin
            state_next.rdata    = ivl_count[7:0];
            state_next.cnt_hold = ivl_count[11:8];
          end
          cat_pkg::OFF_CNT_UPPER: begin
            state_next.rdata = {4'h0, state_reg.cnt_hold};
          end
          cat_pkg::OFF_RELOAD_LOW: begin
            state_next.rdata = state_reg.rl_low;
          end
          cat_pkg::OFF_RELOAD_UP: begin
            state_next.rdata = {4'h0, state_reg.rl_up};
          end
          cat_pkg::OFF_CFG: begin
            state_next.rdata = state_reg.cfg & cat_pkg::CFG_MASK;
          end
          cat_pkg::OFF_IRQ_ENABLE: begin
            state_next.rdata = {4'h0, state_reg.ien};
          end
          cat_pkg::OFF_IRQ_FLAGS: begin
            state_next.rdata = {4'h0, state_reg.flags};
          end
          default: begin
            state_next.rdata = cat_pkg::RST_BYTE;
          end
        endcase
      end
    end

    // Writes; reserved bits are dropped
    if (bus.wr) begin
      if (hit(bus, cat_pkg::OFF_RELOAD_LOW)) begin
        state_next.rl_low = bus.wdata;
      end
      if (hit(bus, cat_pkg::OFF_RELOAD_UP)) begin
        state_next.rl_up = bus.wdata[3:0];
      end
      if (hit(bus, cat_pkg::OFF_CFG)) begin
        state_next.cfg = bus.wdata & cat_pkg::CFG_MASK;
      end
      if (hit(bus, cat_pkg::OFF_IRQ_ENABLE)) begin
        state_next.ien = bus.wdata[3:0];
      end
      if (hit(bus, cat_pkg::OFF_IRQ_FLAGS)) begin
        // Write one to clear
        state_next.flags = state_reg.flags & ~bus.wdata[3:0];
      end
    end

    // Captures run after the read rearm so an edge in the read cycle is kept
    for (int e = 0; e < 4; e++) begin
      if (edge_ev[e] && live[e]) begin
        if (!(hold && state_next.full[e])) begin
          state_next.full[e] = 1'b1;
          if (chain) begin
            state_next.cap[e]     = state_reg.frt[7:0];
            state_next.cap[(e + 2) % 4] = state_reg.frt[15:8];
          end else begin
            state_next.cap[e] = sel;
          end
        end
      end
    end

    // A new edge wins over a clear in the same cycle
    state_next.flags = state_next.flags | (edge_ev & live);
    state_next.irq   = |(state_next.flags & state_next.ien);
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata_out          = state_reg.rdata;
  assign irq_out            = state_reg.irq;
  assign interval_event_out = state_reg.pit;

endmodule

// [testbench/cat_timer_top_chk.sv]
// Port-level assertions for the capture and interval timer block.
// Assumes binding to cat_timer_top; sees only its ports.
`timescale 1ns/1ps
module cat_timer_top_chk (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic [7:0] rdata_out,
  input  wire logic       irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  idle_rdata_a: assert property (!rd_in |=> rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  unmapped_read_a: assert property (rd_in && (addr_in < 8'h22 || addr_in > 8'h2C) |=> rdata_out == 8'h00)
    else $error("unmapped read not zero");
  upper_resv_a: assert property (rd_in && addr_in inside {8'h27, 8'h29, 8'h2B, 8'h2C} |=> rdata_out[7:4] == 4'h0)
    else $error("reserved upper bits not zero");
  cfg_back_a: assert property (wr_in && addr_in == 8'h2A ##1 !wr_in ##1 rd_in && addr_in == 8'h2A
    |=> rdata_out == ($past(wdata_in, 3) & 8'hF8)) else $error("config readback wrong");
  reload_low_a: assert property (wr_in && addr_in == 8'h28 ##1 !wr_in ##1 rd_in && addr_in == 8'h28
    |=> rdata_out == $past(wdata_in, 3)) else $error("reload low readback wrong");
  reload_up_a: assert property (wr_in && addr_in == 8'h29 ##1 !wr_in ##1 rd_in && addr_in == 8'h29
    |=> rdata_out == ($past(wdata_in, 3) & 8'h0F)) else $error("reload upper readback wrong");
  irq_enable_a: assert property (wr_in && addr_in == 8'h2B ##1 !wr_in ##1 rd_in && addr_in == 8'h2B
    |=> rdata_out == ($past(wdata_in, 3) & 8'h0F)) else $error("enable readback wrong");
  irq_masked_a: assert property (wr_in && addr_in == 8'h2B && wdata_in[3:0] == 4'h0 |=> !irq_out)
    else $error("interrupt high with all enables clear");
endmodule
bind cat_timer_top cat_timer_top_chk cat_timer_top_chk_inst (.clk_in(clk_in), .resetn_in(resetn_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out));

// [testbench/tb_cat_timer_top.sv]
// Self-checking bench for the capture and interval timer block.
// Assumes a free-running timer from reset and registered read data.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_cat_timer_top;
  logic       clk_in = 1'b0;
  logic       resetn_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_in = 1'b0;
  logic       rd_in = 1'b0;
  logic       capture_input_zero_in = 1'b0;
  logic       capture_input_one_in = 1'b0;
  logic [7:0] rdata_out;
  logic       irq_out;
  logic       interval_event_out;
  int         mismatches = 0;
  int         num_checks = 0;
  cat_timer_top cat_timer_top_inst (.clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .capture_input_zero_in(capture_input_zero_in),
    .capture_input_one_in(capture_input_one_in), .rdata_out(rdata_out), .irq_out(irq_out),
    .interval_event_out(interval_event_out));
  initial forever #2 clk_in = ~clk_in;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK("read data", e, d)
  endtask
  task automatic pins(input logic v, input int w);
    capture_input_zero_in <= v;
    capture_input_one_in <= v;
    repeat (w) @(posedge clk_in);
  endtask
  task automatic wait_ev(output int n);
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (interval_event_out !== 1'b1 && n < 5000);
  endtask
  // Edges at 0, d, 2d, 4d: latest pair spans 2d, first pair spans d
  task automatic cap_run(input logic [7:0] cfg, input logic [3:0] ie, input int d);
    logic [7:0] r0, f0, r1, f1, flg;
    int span;
    wr(8'h2A, cfg | 8'h07);
    rdchk(8'h2A, cfg);
    wr(8'h2B, {4'hF, ie});
    rdchk(8'h2B, {4'h0, ie});
    @(posedge clk_in);
    pins(1'b1, d);
    pins(1'b0, d);
    pins(1'b1, 2 * d);
    pins(1'b0, 8);
    span = cfg[7] ? d : 2 * d;
    flg = cfg[3] ? 8'h03 : 8'h0F;
    rd(8'h22, r0);
    rd(8'h24, f0);
    rd(8'h23, r1);
    rd(8'h25, f1);
    if (cfg[3]) begin
      `CHK("wide span", 16'(span), {f1, f0} - {r1, r0})
    end else begin
      `CHK("span zero", 8'(span >> cfg[6:4]), f0 - r0)
      `CHK("span one", 8'(span >> cfg[6:4]), f1 - r1)
    end
    rdchk(8'h2C, flg);
    `CHK("irq set", |(ie & flg[3:0]), irq_out)
    wr(8'h2C, 8'hFF);
    rdchk(8'h2C, 8'h00);
    `CHK("irq clear", 1'b0, irq_out)
  endtask
  task automatic count_run;
    logic [7:0] l1, h1, l2, h2;
    int n;
    int c1;
    int c2;
    wr(8'h28, 8'h34);
    rdchk(8'h28, 8'h34);
    wr(8'h29, 8'hF5);
    rdchk(8'h29, 8'h05);
    wait_ev(n);
    wait_ev(n);
    `CHK("interval period", 12'h535, n)
    rd(8'h26, l1);
    repeat (300) @(posedge clk_in);
    rd(8'h27, h1);
    rd(8'h26, l2);
    rd(8'h27, h2);
    c1 = {h1[3:0], l1};
    c2 = {h2[3:0], l2};
    // Two low reads 304 cycles apart; wrap taken modulo the period
    `CHK("held count gap", 304, (c1 - c2 + 12'h535) % 12'h535)
    `CHK("count upper resv", 4'h0, h1[7:4])
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    resetn_in <= 1'b1;
    for (int a = 8'h27; a <= 8'h2C; a++) begin
      rdchk(8'(a), 8'h00);
    end
    wr(8'h30, 8'hFF);
    rdchk(8'h30, 8'h00);
    for (int n = 0; n < 8; n++) begin
      cap_run({1'b0, 3'(n), 4'h0}, 4'h1, 3 << n);
    end
    cap_run(8'hA0, 4'h0, 12);
    cap_run(8'h08, 4'h3, 300);
    count_run();
    tally_and_finish();
  end
  initial begin
    repeat (40000) @(posedge clk_in);
    mismatches++;
    tally_and_finish();
  end
endmodule
